// File: dma_consts.vh
// register offsets, control fields and size codes of the dma controller
`ifndef DMA_CONSTS_VH
`define DMA_CONSTS_VH
`define DMA_NCH         8
// per-channel registers: channel index in addr[6:4], register in addr[3:2]
`define DMA_OFS_CTRL    2'h0
`define DMA_OFS_PBASE   2'h1
`define DMA_OFS_MBASE   2'h2
`define DMA_OFS_COUNT   2'h3
// global registers
`define DMA_ADR_FLAGS   8'h80
`define DMA_ADR_CLEAR   8'h84
`define DMA_ADR_TRIG    8'h88
// control register fields
`define CTL_EN          0
`define CTL_TRANSFER_COMPLETE_IRQ_ENABLE        1
`define CTL_HALF_TRANSFER_IRQ_ENABLE        2
`define CTL_DIR         3
`define CTL_CIRCULAR_ENABLE        4
`define CTL_PERIPH_PTR_INCREMENT        5
`define CTL_MEM_PTR_INCREMENT        6
`define CTL_PERIPH_ITEM_WIDTH_LO    8
`define CTL_MEM_ITEM_WIDTH_LO    10
`define CTL_PL_LO       12
`define CTL_M2M         14
`define CTL_WIDTH       15
`define CTL_RESET       15'h0000
// item size codes
`define SZ_BYTE         2'h0
`define SZ_HALF         2'h1
`define SZ_WORD         2'h2
`endif

// File: dma_arbiter.v
// fixed-level priority arbiter with lowest-index tie break
`timescale 1ns/10ps
`default_nettype none
module dma_arbiter (
	// requests and their levels, two bits per channel
	input  wire [7:0]  pend_i,
	input  wire [15:0] level_i,
	// winner
	output reg         valid_o,
	output reg  [2:0]  grant_o
);
	reg [1:0] best;
	integer   i;
	always @* begin
		best    = 2'h0;
		valid_o = 1'b0;
		grant_o = 3'h0;
		// scanning downward with >= lets the lower index win a tie
		for (i = 7; i >= 0; i = i - 1) begin
			if (pend_i[i] && (!valid_o || level_i[2*i +: 2] >= best)) begin
				valid_o = 1'b1;
				best    = level_i[2*i +: 2];
				grant_o = i[2:0];
			end
		end
	end
endmodule
`default_nettype wire

// File: dma_controller.v
// eight-channel dma controller: registers, channel state and transfer engine
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "dma_consts.vh"
module dma_controller (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// register port
	input  wire [7:0]  addr_i,
	input  wire [31:0] wdata_i,
	input  wire        wr_i,
	input  wire        rd_i,
	output reg  [31:0] rdata_o,
	// system bus master
	output reg         bus_req_o,
	output reg         bus_we_o,
	output reg  [31:0] bus_addr_o,
	output reg  [1:0]  bus_size_o,
	output reg  [31:0] bus_wdata_o,
	input  wire [31:0] bus_rdata_i,
	input  wire        bus_done_i,
	// peripheral handshake
	input  wire [7:0]  per_req_i,
	output reg  [7:0]  per_ack_o,
	// channel interrupts
	output reg  [7:0]  irq_o
);
	// ****************************************
	// states
	// ****************************************
	localparam ST_IDLE = 3'h0;
	localparam ST_RD   = 3'h1;
	localparam ST_WR   = 3'h2;
	localparam ST_ACK  = 3'h3;
	localparam ST_GAP  = 3'h4;

	// ****************************************
	// storage
	// ****************************************
	reg [`CTL_WIDTH-1:0] ctrl_r [0:7];
	reg [31:0]           pbase_r [0:7];
	reg [31:0]           mbase_r [0:7];
	reg [31:0]           pcur_r [0:7];
	reg [31:0]           mcur_r [0:7];
	reg [15:0]           cnt_r [0:7];
	reg [15:0]           cinit_r [0:7];
	reg [7:0]            ht_r;
	reg [7:0]            tc_r;
	reg [7:0]            trig_r;
	reg [7:0]            req_s1_r;
	reg [7:0]            req_s2_r;
	reg [2:0]            st_r;
	reg [2:0]            ch_r;
	reg                  per_srv_r;
	reg [31:0]           data_r;

	// ****************************************
	// pending and arbitration
	// ****************************************
	reg  [7:0]  pend;
	reg  [15:0] level;
	wire        win_v;
	wire [2:0]  win_ch;
	integer     k;
	always @* begin
		for (k = 0; k < 8; k = k + 1) begin
			level[2*k +: 2] = ctrl_r[k][`CTL_PL_LO +: 2];
			// count zero blocks a channel until reloaded
			pend[k] = ctrl_r[k][`CTL_EN] && (cnt_r[k] != 16'h0000) && !per_ack_o[k] &&
				(ctrl_r[k][`CTL_M2M] || req_s2_r[k] || trig_r[k]);
		end
	end

	dma_arbiter u_arb (
		.pend_i  (pend),
		.level_i (level),
		.valid_o (win_v),
		.grant_o (win_ch)
	);

	// ****************************************
	// current channel view
	// ****************************************
	wire [`CTL_WIDTH-1:0] cc   = ctrl_r[ch_r];
	wire                  dir  = cc[`CTL_DIR];
	wire [1:0]            psz  = cc[`CTL_PERIPH_ITEM_WIDTH_LO +: 2];
	wire [1:0]            msz  = cc[`CTL_MEM_ITEM_WIDTH_LO +: 2];
	// direction picks which pointer is source, so all four pairings are just addresses
	wire [31:0] src_a  = dir ? mcur_r[ch_r] : pcur_r[ch_r];
	wire [31:0] dst_a  = dir ? pcur_r[ch_r] : mcur_r[ch_r];
	wire [1:0]  src_sz = dir ? msz : psz;
	wire [1:0]  dst_sz = dir ? psz : msz;
	wire [15:0] cnt_dec = cnt_r[ch_r] - 16'h0001;

	// ****************************************
	// item helpers
	// ****************************************
	function [31:0] step;
		input [1:0] sz;
		begin
			case (sz)
				`SZ_BYTE: step = 32'h00000001;
				`SZ_HALF: step = 32'h00000002;
				default:  step = 32'h00000004;
			endcase
		end
	endfunction

	function [31:0] narrow;
		input [31:0] d;
		input [1:0]  sz;
		begin
			case (sz)
				`SZ_BYTE: narrow = {24'h000000, d[7:0]};
				`SZ_HALF: narrow = {16'h0000, d[15:0]};
				default:  narrow = d;
			endcase
		end
	endfunction

	// ****************************************
	// register decode
	// ****************************************
	wire       glob   = addr_i[7];
	wire [2:0] rch    = addr_i[6:4];
	wire [1:0] rofs   = addr_i[3:2];
	wire       wr_ch  = wr_i && !glob;
	wire       wr_clr = wr_i && (addr_i == `DMA_ADR_CLEAR);
	wire       wr_trg = wr_i && (addr_i == `DMA_ADR_TRIG);

	// ****************************************
	// sequencing
	// ****************************************
	wire       fin     = (st_r == ST_WR) && bus_done_i;
	wire       last    = fin && (cnt_dec == 16'h0000);
	wire       circular_enable_rl = last && cc[`CTL_CIRCULAR_ENABLE] && !cc[`CTL_M2M];
	// one-hot of the channel taken this cycle, whether by request, trigger or memory-to-memory mode
	wire [7:0] trig_take = (st_r == ST_IDLE && win_v) ? (8'h01 << win_ch) : 8'h00;
	reg  [7:0] ht_set;
	reg  [7:0] tc_set;
	always @* begin
		ht_set = 8'h00;
		tc_set = 8'h00;
		if (fin) begin
			// half point: items left equal half of the programmed count
			ht_set[ch_r] = (cnt_dec == (cinit_r[ch_r] >> 1));
			tc_set[ch_r] = last;
		end
	end


	// ****************************************
	// clocked state
	// ****************************************
	integer c;
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (c = 0; c < 8; c = c + 1) begin
				ctrl_r[c]  <= `CTL_RESET;
				pbase_r[c] <= 32'h00000000;
				mbase_r[c] <= 32'h00000000;
				pcur_r[c]  <= 32'h00000000;
				mcur_r[c]  <= 32'h00000000;
				cnt_r[c]   <= 16'h0000;
				cinit_r[c] <= 16'h0000;
			end
			ht_r        <= 8'h00;
			tc_r        <= 8'h00;
			trig_r      <= 8'h00;
			req_s1_r    <= 8'h00;
			req_s2_r    <= 8'h00;
			st_r        <= ST_IDLE;
			ch_r        <= 3'h0;
			per_srv_r   <= 1'b0;
			data_r      <= 32'h00000000;
			per_ack_o   <= 8'h00;
			bus_req_o   <= 1'b0;
			bus_we_o    <= 1'b0;
			bus_addr_o  <= 32'h00000000;
			bus_size_o  <= `SZ_BYTE;
			bus_wdata_o <= 32'h00000000;
			rdata_o     <= 32'h00000000;
			irq_o       <= 8'h00;
		end else begin

			// ****************************************
			// request synchroniser
			// ****************************************
			req_s1_r <= per_req_i;
			req_s2_r <= req_s1_r;


			// ****************************************
			// register write port
			// ****************************************
			// register writes; disabling touches nothing else
			if (wr_ch) begin
				case (rofs)
					`DMA_OFS_CTRL:  ctrl_r[rch] <= wdata_i[`CTL_WIDTH-1:0];
					`DMA_OFS_PBASE: begin
						pbase_r[rch] <= wdata_i;
						pcur_r[rch]  <= wdata_i;
					end
					`DMA_OFS_MBASE: begin
						mbase_r[rch] <= wdata_i;
						mcur_r[rch]  <= wdata_i;
					end
					default: begin
						// a live channel would race the decrement, so it refuses
						if (!ctrl_r[rch][`CTL_EN]) begin
							cnt_r[rch]   <= wdata_i[15:0];
							cinit_r[rch] <= wdata_i[15:0];
						end
					end
				endcase
			end


			// ****************************************
			// flags and interrupts
			// ****************************************
			// sticky flags: a hardware set beats a same-cycle clear
			ht_r <= (ht_r & ~(wr_clr ? wdata_i[7:0] : 8'h00)) | ht_set;
			tc_r <= (tc_r & ~(wr_clr ? wdata_i[15:8] : 8'h00)) | tc_set;
			for (c = 0; c < 8; c = c + 1) begin
				irq_o[c] <= ((ht_r[c] | ht_set[c]) & ctrl_r[c][`CTL_HALF_TRANSFER_IRQ_ENABLE]) |
					((tc_r[c] | tc_set[c]) & ctrl_r[c][`CTL_TRANSFER_COMPLETE_IRQ_ENABLE]);
			end


			// ****************************************
			// software trigger
			// ****************************************
			// software trigger held until its channel is taken
			trig_r <= (trig_r | (wr_trg ? wdata_i[7:0] : 8'h00)) & ~trig_take;


			// ****************************************
			// transaction engine
			// ****************************************
			case (st_r)
				ST_IDLE: begin
					// one transaction per grant; next grant re-arbitrates
					if (win_v) begin
						ch_r       <= win_ch;
						per_srv_r  <= !ctrl_r[win_ch][`CTL_M2M] && req_s2_r[win_ch];
						st_r       <= ST_RD;
						bus_req_o  <= 1'b1;
						bus_we_o   <= 1'b0;
						bus_addr_o <= ctrl_r[win_ch][`CTL_DIR] ? mcur_r[win_ch] : pcur_r[win_ch];
						bus_size_o <= ctrl_r[win_ch][`CTL_DIR] ?
							ctrl_r[win_ch][`CTL_MEM_ITEM_WIDTH_LO +: 2] : ctrl_r[win_ch][`CTL_PERIPH_ITEM_WIDTH_LO +: 2];
						// acknowledge rises with the read that opens the transfer, whichever side is the peripheral
						if (!ctrl_r[win_ch][`CTL_M2M] && req_s2_r[win_ch])
							per_ack_o[win_ch] <= 1'b1;
					end
				end
				ST_RD: begin
					if (bus_done_i) begin
						data_r      <= narrow(bus_rdata_i, src_sz);
						bus_we_o    <= 1'b1;
						bus_addr_o  <= dst_a;
						bus_size_o  <= dst_sz;
						bus_wdata_o <= narrow(bus_rdata_i, src_sz);
						st_r        <= ST_WR;
					end
				end
				ST_WR: begin
					if (bus_done_i) begin
						bus_req_o <= 1'b0;
						bus_we_o  <= 1'b0;
						if (circular_enable_rl) begin
							cnt_r[ch_r]  <= cinit_r[ch_r];
							pcur_r[ch_r] <= pbase_r[ch_r];
							mcur_r[ch_r] <= mbase_r[ch_r];
						end else begin
							cnt_r[ch_r] <= cnt_dec;
							if (cc[`CTL_PERIPH_PTR_INCREMENT])
								pcur_r[ch_r] <= pcur_r[ch_r] + step(psz);
							if (cc[`CTL_MEM_PTR_INCREMENT])
								mcur_r[ch_r] <= mcur_r[ch_r] + step(msz);
						end
						st_r <= per_srv_r ? ST_ACK : ST_GAP;
					end
				end
				ST_ACK: begin
					// hold until the synchronised request is seen low
					if (!req_s2_r[ch_r]) begin
						per_ack_o[ch_r] <= 1'b0;
						st_r            <= ST_IDLE;
					end
				end
				ST_GAP: begin
					// one idle bus cycle lets the matrix rotate to other masters
					st_r <= ST_IDLE;
				end
				default: st_r <= ST_IDLE;
			endcase


			// ****************************************
			// register read port
			// ****************************************
			// register reads, answered next cycle; current pointers not mapped
			if (rd_i) begin
				if (!glob) begin
					case (rofs)
						`DMA_OFS_CTRL:  rdata_o <= {17'h00000, ctrl_r[rch]};
						`DMA_OFS_PBASE: rdata_o <= pbase_r[rch];
						`DMA_OFS_MBASE: rdata_o <= mbase_r[rch];
						default:        rdata_o <= {16'h0000, cnt_r[rch]};
					endcase
				end else if (addr_i == `DMA_ADR_FLAGS) begin
					rdata_o <= {16'h0000, tc_r, ht_r};
				end else begin
					rdata_o <= 32'h00000000;
				end
			end else begin
				rdata_o <= 32'h00000000;
			end
		end
	end
endmodule
`default_nettype wire

// File: dma_props.sv
// port assertions for the dma controller
`timescale 1ns/10ps
`default_nettype none
module dma_props (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic        bus_req_o,
	input wire logic        bus_we_o,
	input wire logic [31:0] bus_addr_o,
	input wire logic        bus_done_i,
	input wire logic [7:0]  per_req_i,
	input wire logic [7:0]  per_ack_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence rd_done; bus_req_o && !bus_we_o && bus_done_i; endsequence
	sequence wr_done; bus_req_o && bus_we_o && bus_done_i; endsequence
	chk_write_follows: assert property (rd_done |=> bus_req_o && bus_we_o)
		else $error("no write after read");
	chk_bus_release: assert property (wr_done |=> !bus_req_o)
		else $error("bus kept after write");
	chk_read_first: assert property ($rose(bus_req_o) |-> !bus_we_o)
		else $error("transfer not opened by read");
	chk_access_stable: assert property (bus_req_o && !bus_done_i |=>
		$stable(bus_addr_o) && $stable(bus_we_o))
		else $error("access changed before done");
	chk_ack_at_read: assert property (|(per_ack_o & ~$past(per_ack_o)) |->
		$rose(bus_req_o) && !bus_we_o)
		else $error("ack not at read start");
	chk_ack_release: assert property (!(|($past(per_ack_o) & ~per_ack_o
		& ($past(per_req_i) | $past(per_req_i, 2)))))
		else $error("ack dropped under request");
	chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside slot");
	chk_end_on_write: assert property ($fell(bus_req_o) |->
		$past(bus_we_o) && $past(bus_done_i))
		else $error("bus dropped mid transfer");
endmodule
bind dma_controller dma_props u_dma_props (.clk_i(clk_i), .rst_i(rst_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .bus_req_o(bus_req_o), .bus_we_o(bus_we_o), .bus_addr_o(bus_addr_o),
	.bus_done_i(bus_done_i), .per_req_i(per_req_i), .per_ack_o(per_ack_o));
`default_nettype wire

// File: dma_partner.sv
// far side: system memory and eight requesting peripherals
`timescale 1ns/10ps
`default_nettype none
module dma_partner (
	// clock, reset and pacing
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        slow_i,
	input  wire logic [7:0]  fire_i,
	// system bus
	input  wire logic        bus_req_i,
	input  wire logic [31:0] bus_addr_i,
	output var  logic [31:0] bus_rdata_o,
	output var  logic        bus_done_o,
	// peripheral handshake
	input  wire logic [7:0]  per_ack_i,
	output var  logic [7:0]  per_req_o
);
	logic [2:0] wait_r;
	// data inverted outside the done cycle so a late sample shows
	always_comb bus_rdata_o = (bus_addr_i * 32'h01010101 + 32'h00112233) ^ {32{!bus_done_o}};
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wait_r <= 3'h0;
			bus_done_o <= 1'b0;
			per_req_o <= 8'h00;
		end else begin
			bus_done_o <= bus_req_i && !bus_done_o && wait_r >= (slow_i ? 3'h4 : 3'h0);
			wait_r <= (bus_req_i && !bus_done_o) ? wait_r + 3'h1 : 3'h0;
			per_req_o <= (per_req_o | fire_i) & ~per_ack_i;
		end
	end
endmodule
`default_nettype wire

// File: test_dma_controller.sv
// self-checking testbench for the dma controller
`timescale 1ns/10ps
`default_nettype none
module test_dma_controller;
	logic        clk_i, rst_i, wr_i, rd_i, bus_req_o, bus_we_o, bus_done_i, slow_i;
	logic [7:0]  addr_i, per_req_i, per_ack_o, irq_o, fire_i;
	logic [31:0] wdata_i, rdata_o, bus_addr_o, bus_wdata_o, bus_rdata_i, exp_r, nrd, k;
	logic [1:0]  bus_size_o;
	int          num_errors, tests_run;
	dma_controller u_dma_controller (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bus_req_o(bus_req_o),
		.bus_we_o(bus_we_o), .bus_addr_o(bus_addr_o), .bus_size_o(bus_size_o),
		.bus_wdata_o(bus_wdata_o), .bus_rdata_i(bus_rdata_i), .bus_done_i(bus_done_i),
		.per_req_i(per_req_i), .per_ack_o(per_ack_o), .irq_o(irq_o));
	dma_partner u_dma_partner (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow_i), .fire_i(fire_i),
		.bus_req_i(bus_req_o), .bus_addr_i(bus_addr_o), .bus_rdata_o(bus_rdata_i),
		.bus_done_o(bus_done_i), .per_ack_i(per_ack_o), .per_req_o(per_req_i));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) if (bus_req_o && bus_done_i && !bus_we_o) nrd <= nrd + 1;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		chk(rdata_o, exp);
	endtask
	task setup(input logic [3:0] c, input logic [31:0] ctl, pb, mb, cnt);
		wr({c, 4'h4}, pb);
		wr({c, 4'h8}, mb);
		wr({c, 4'hC}, cnt);
		wr({c, 4'h0}, ctl);
	endtask
	task fire(input logic [7:0] m);
		@(posedge clk_i);
		fire_i <= m;
		@(posedge clk_i);
		fire_i <= 8'h00;
	endtask
	// bounded wait for a completed read or write phase
	task wt(input logic w);
		int n;
		n = 0;
		@(negedge clk_i);
		while (!(bus_req_o && bus_done_i && bus_we_o === w) && n < 60) begin
			@(negedge clk_i);
			n++;
		end
		if (n == 60) chk(32'h0, 32'h1);
	endtask
	task xfer(input logic [31:0] s, input logic [31:0] d, input logic [31:0] m);
		wt(1'b0);
		chk(bus_addr_o, s);
		exp_r = (s * 32'h01010101 + 32'h00112233) & m;
		wt(1'b1);
		chk(bus_addr_o, d);
		chk(bus_wdata_o, exp_r);
	endtask
	task complete_run;
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		complete_run;
	end
	initial begin
		rst_i = 1'b1;
		{wr_i, rd_i, slow_i, addr_i, wdata_i, fire_i, nrd} = '0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(8'h30, 32'h0);
		setup(4'h3, 32'h447, 32'h100, 32'h2000, 32'h4);
		wr(8'h3C, 32'h9);
		rd(8'h3C, 32'h4);
		for (k = 0; k < 4; k++) begin
			fire(8'h08);
			xfer(32'h100, 32'h2000 + 2 * k, 32'hFF);
			if (k == 0) chk({30'h0, bus_size_o}, 32'h1);
			repeat (6) @(posedge clk_i);
			if (k == 1) rd(8'h80, 32'h08);
			if (k == 1) chk({24'h0, irq_o}, 32'h08);
		end
		rd(8'h3C, 32'h0);
		rd(8'h80, 32'h0808);
		k = nrd;
		fire(8'h08);
		repeat (20) @(posedge clk_i);
		chk(nrd, k);
		wr(8'h84, 32'h0808);
		repeat (2) @(negedge clk_i);
		chk({24'h0, irq_o}, 32'h0);
		wr(8'h30, 32'h446);
		rd(8'h30, 32'h446);
		rd(8'h34, 32'h100);
		rd(8'h8C, 32'h0);
		$display("single channel done");
		// ties go to the lower index, then level beats index
		setup(4'h2, 32'h1001, 32'h200, 32'h0, 32'h1);
		setup(4'h4, 32'h1001, 32'h400, 32'h0, 32'h1);
		fire(8'h14);
		xfer(32'h200, 32'h0, 32'hFF);
		xfer(32'h400, 32'h0, 32'hFF);
		setup(4'h1, 32'h1, 32'h150, 32'h0, 32'h1);
		setup(4'h5, 32'h3001, 32'h500, 32'h0, 32'h1);
		fire(8'h22);
		xfer(32'h500, 32'h0, 32'hFF);
		xfer(32'h150, 32'h0, 32'hFF);
		$display("priority done");
		slow_i <= 1'b1;
		setup(4'h6, 32'hA31, 32'h600, 32'h60, 32'h2);
		for (k = 0; k < 3; k++) begin
			fire(8'h40);
			xfer(32'h600 + 4 * k[0], 32'h60, 32'hFFFFFFFF);
			repeat (8) @(posedge clk_i);
		end
		rd(8'h6C, 32'h1);
		wr(8'h60, 32'hA30);
		slow_i <= 1'b0;
		$display("circular done");
		setup(4'h7, 32'h4061, 32'h700, 32'h80, 32'h2);
		xfer(32'h700, 32'h80, 32'hFF);
		xfer(32'h701, 32'h81, 32'hFF);
		rd(8'h7C, 32'h0);
		// memory source toward the peripheral side, started by software
		setup(4'h0, 32'h9, 32'h10, 32'h20, 32'h1);
		wr(8'h88, 32'h1);
		xfer(32'h20, 32'h10, 32'hFF);
		$display("memory and trigger done");
		complete_run;
	end
endmodule
`default_nettype wire
